// ### src/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_W          12
`define CS_INDEX        10'h000
`define MOD_INDEX       10'h001
`define CNT_INDEX       10'h002

`define EN_BIT          0
`define RLD_BIT         1
`define FLAG_BIT        2
`define IE_BIT          3
`define OVW_BIT         4
`define DBG_BIT         5
`define DOZE_BIT        6
`define PRE_MSB         11
`define PRE_LSB         8

`define MOD_RESET       16'hffff
`define CNT_RESET       16'hffff
`define CNT_ROLL        16'hffff
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
`define PRESCALE_RESET  16'hffff
`define PRE_RESET       4'h0

`endif

// ### src/timer_pkg.sv
`include "timer_defines.svh"

package timer_pkg;
    typedef logic [15:0]         word16_type;
    typedef logic [3:0]          prescale_sel_type;
    typedef logic [`ADDR_W-3:0]  reg_index_type;
endpackage

// ### src/tick_prescaler.sv
`timescale 1ns/100ps
`include "timer_defines.svh"

module tick_prescaler
    import timer_pkg::*;
(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control from the timer.
    input  wire logic             run,
    input  wire logic             restart,
    input  wire prescale_sel_type pre_sel,
    // Divided tick.
    output logic                  tick
);

    word16_type count_reg;
    word16_type mask;

    // The mask holds as many low ones as the exponent of the selected power of two.
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_mask
            assign mask[i] = (pre_sel > i);
        end
    endgenerate

    // The tick does not look at restart, so the reload that a tick causes
    // cannot feed back into the tick itself.
    assign tick = run && ((count_reg & mask) == `CNT_ZERO);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `PRESCALE_RESET;
        end else if (restart) begin
            count_reg <= `PRESCALE_RESET;
        end else if (run) begin
            count_reg <= count_reg - `CNT_ONE;
        end
    end

    restart_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> count_reg == `PRESCALE_RESET)
        else $error("Prescaler not reset after restart.");
    stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run && !restart) |=> $stable(count_reg) && !$past(tick))
        else $error("Prescaler moved while stopped.");

endmodule

// ### src/periodic_down_timer.sv
`timescale 1ns/100ps
`include "timer_defines.svh"

module periodic_down_timer
    import timer_pkg::*;
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [`ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // System mode inputs, same clock domain.
    input  wire logic              doze_mode,
    input  wire logic              debug_mode,
    // Interrupt request.
    output logic                   zero_irq
);

    // Control and status state.
    logic             run_enable_reg;
    logic             reload_select_reg;
    logic             zero_reached_flag_reg;
    logic             zero_irq_enable_reg;
    logic             overwrite_select_reg;
    logic             debug_stop_reg;
    logic             doze_stop_reg;
    prescale_sel_type pre_sel_reg;

    // Counting state.
    word16_type       modulus_value_reg;
    word16_type       count_reg;
    word16_type       count_next;
    logic [31:0]      prdata_reg;

    // Decode and event terms.
    reg_index_type    index;
    logic             aligned;
    logic             mapped;
    logic             setup;
    logic             wr_access;
    logic             cs_write;
    logic             mod_write;
    logic             overwrite_load;
    logic             reload_load;
    logic             tick;
    logic             run;
    logic             reach_zero;
    logic             flag_clear;
    logic             pre_write;
    logic [31:0]      read_value;

    assign index     = paddr[`ADDR_W-1:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign mapped    = aligned && (index == `CS_INDEX || index == `MOD_INDEX ||
                                   index == `CNT_INDEX);
    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite && mapped;
    assign cs_write  = wr_access && (index == `CS_INDEX);
    assign mod_write = wr_access && (index == `MOD_INDEX);

    // Every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    // Freeze in doze or debug only when the matching stop bit is set.
    // Register accesses stay live either way, so debug edits are kept.
    assign run = run_enable_reg
              && !(doze_mode && doze_stop_reg)
              && !(debug_mode && debug_stop_reg);

    assign pre_write      = cs_write &&
                            (pwdata[`PRE_MSB:`PRE_LSB] != pre_sel_reg);
    assign overwrite_load = mod_write && overwrite_select_reg;
    assign reload_load    = tick && (count_reg == `CNT_ZERO) && reload_select_reg;
    assign reach_zero     = tick && !overwrite_load && (count_reg == `CNT_ONE);

    tick_prescaler prescaler_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .restart (pre_write || overwrite_load || reload_load),
        .pre_sel (pre_sel_reg),
        .tick    (tick)
    );

    // Counter next value; a software overwrite beats a tick in the same cycle.
    always_comb begin
        count_next = count_reg;
        if (overwrite_load) begin
            count_next = pwdata[15:0];
        end else if (tick) begin
            if (count_reg == `CNT_ZERO) begin
                if (reload_select_reg) begin
                    count_next = modulus_value_reg;
                end else begin
                    count_next = `CNT_ROLL;
                end
            end else begin
                count_next = count_reg - `CNT_ONE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // Modulus latch; without overwrite it waits here for a reload at the next zero, which happens only with reload selected.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modulus_value_reg <= `MOD_RESET;
        end else if (mod_write) begin
            modulus_value_reg <= pwdata[15:0];
        end
    end

    // Control bits, writable at any time including debug mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_enable_reg       <= 1'b0;
            reload_select_reg    <= 1'b0;
            zero_irq_enable_reg  <= 1'b0;
            overwrite_select_reg <= 1'b0;
            debug_stop_reg       <= 1'b0;
            doze_stop_reg        <= 1'b0;
            pre_sel_reg          <= `PRE_RESET;
        end else if (cs_write) begin
            run_enable_reg       <= pwdata[`EN_BIT];
            reload_select_reg    <= pwdata[`RLD_BIT];
            zero_irq_enable_reg  <= pwdata[`IE_BIT];
            overwrite_select_reg <= pwdata[`OVW_BIT];
            debug_stop_reg       <= pwdata[`DBG_BIT];
            doze_stop_reg        <= pwdata[`DOZE_BIT];
            pre_sel_reg          <= pwdata[`PRE_MSB:`PRE_LSB];
        end
    end

    // A zero reached in the same cycle as a clear still leaves the flag set.
    assign flag_clear = (cs_write && pwdata[`FLAG_BIT]) || mod_write;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_reached_flag_reg <= 1'b0;
        end else begin
            zero_reached_flag_reg <= reach_zero ||
                                     (zero_reached_flag_reg && !flag_clear);
        end
    end

    assign zero_irq = zero_reached_flag_reg && zero_irq_enable_reg;

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_comb begin
        read_value = 32'h0000_0000;
        if (aligned && index == `CS_INDEX) begin
            read_value[`EN_BIT]            = run_enable_reg;
            read_value[`RLD_BIT]           = reload_select_reg;
            read_value[`FLAG_BIT]          = zero_reached_flag_reg;
            read_value[`IE_BIT]            = zero_irq_enable_reg;
            read_value[`OVW_BIT]           = overwrite_select_reg;
            read_value[`DBG_BIT]           = debug_stop_reg;
            read_value[`DOZE_BIT]          = doze_stop_reg;
            read_value[`PRE_MSB:`PRE_LSB]  = pre_sel_reg;
        end else if (aligned && index == `MOD_INDEX) begin
            read_value[15:0] = modulus_value_reg;
        end else if (aligned && index == `CNT_INDEX) begin
            read_value[15:0] = count_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
        end
    end

    // Checks.
    stopped_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_enable_reg && !overwrite_load) |=> $stable(count_reg))
        else $error("Counter moved while disabled.");

    doze_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        (doze_mode && doze_stop_reg) |-> !tick)
        else $error("Tick seen while frozen in doze.");

    debug_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && debug_stop_reg && !overwrite_load) |=> $stable(count_reg))
        else $error("Counter moved while frozen in debug.");

    debug_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && cs_write && !pwdata[`DBG_BIT] && pwdata[`EN_BIT]
         && !doze_mode) |=> run)
        else $error("Timer not started by clearing debug stop.");

    overwrite_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        overwrite_load |=> count_reg == $past(pwdata[15:0]))
        else $error("Overwrite did not load the counter.");

    latch_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mod_write && !overwrite_select_reg && !tick) |=> $stable(count_reg))
        else $error("Modulus write changed the count without overwrite.");

    reload_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reload_load && !overwrite_load) |=> count_reg == $past(modulus_value_reg))
        else $error("Counter not reloaded from modulus.");

    roll_over_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && count_reg == `CNT_ZERO && !reload_select_reg && !overwrite_load)
        |=> count_reg == `CNT_ROLL)
        else $error("Counter did not roll over.");

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        reach_zero |=> zero_reached_flag_reg && count_reg == `CNT_ZERO)
        else $error("Flag not set on reaching zero.");

    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clear && !reach_zero) |=> !zero_reached_flag_reg)
        else $error("Flag not cleared by software.");

    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (zero_reached_flag_reg && !flag_clear) |=> zero_reached_flag_reg)
        else $error("Flag dropped without a clear.");

    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cs_write && !pwdata[`IE_BIT]) |=> !zero_irq)
        else $error("Request raised with interrupt enable clear.");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reach_zero && zero_irq_enable_reg && !cs_write) |=> zero_irq [*2] or
        (zero_irq ##1 flag_clear))
        else $error("Request not held as a level.");

    modulus_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && aligned && index == `MOD_INDEX)
        |=> prdata[15:0] == $past(modulus_value_reg))
        else $error("Modulus read did not return the latch.");

    // Run cycles since the last tick or prescaler restart, kept only for the checks below.
    // It models the divider by counting, so a slip in the mask logic shows up as a mismatch.
    word16_type       tick_gap_reg;
    word16_type       tick_span;
    logic             pre_restart;

    assign pre_restart = pre_write || overwrite_load || reload_load;
    assign tick_span   = (`CNT_ONE << pre_sel_reg) - `CNT_ONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_gap_reg <= `CNT_ZERO;
        end else if (pre_restart || tick) begin
            tick_gap_reg <= `CNT_ZERO;
        end else if (run) begin
            tick_gap_reg <= tick_gap_reg + `CNT_ONE;
        end
    end

    tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
        run |-> tick == (tick_gap_reg == tick_span))
        else $error("Tick spacing differs from the selected divisor.");

    prescale_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pre_write && pwdata[`PRE_MSB:`PRE_LSB] != `PRE_RESET) |=> !tick)
        else $error("Prescaler not restarted by a new divisor.");

    overwrite_prescale_a: assert property (@(posedge pclk) disable iff (!presetn)
        (overwrite_load && pre_sel_reg != `PRE_RESET) |=> !tick)
        else $error("Prescaler not restarted by an overwrite.");

    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && count_reg != `CNT_ZERO && !overwrite_load)
        |=> count_reg == $past(count_reg) - `CNT_ONE)
        else $error("Counter did not step down by one.");

    doze_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        (doze_mode && !doze_stop_reg && run_enable_reg && !(debug_mode && debug_stop_reg))
        |-> run)
        else $error("Doze stopped the timer with doze-stop clear.");

    debug_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && cs_write && pwdata[`DBG_BIT]) |=> !run || !debug_mode)
        else $error("Timer not stopped by setting debug stop.");

    debug_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && cs_write)
        |=> run_enable_reg == $past(pwdata[`EN_BIT])
            && pre_sel_reg == $past(pwdata[`PRE_MSB:`PRE_LSB]))
        else $error("Control write lost in debug mode.");

    modulus_debug_a: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && mod_write) |=> modulus_value_reg == $past(pwdata[15:0]))
        else $error("Modulus write lost in debug mode.");

    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !mod_write |=> $stable(modulus_value_reg))
        else $error("Modulus latch changed without a write.");

    count_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && index == `CNT_INDEX)
        |=> $stable(modulus_value_reg) && $stable(pre_sel_reg))
        else $error("Write to the count register had an effect.");

    count_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && aligned && index == `CNT_INDEX)
        |=> prdata[15:0] == $past(count_reg))
        else $error("Count read did not return the counter.");

    reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && aligned && index == `CS_INDEX)
        |=> prdata[`PRE_LSB-1] == 1'b0 && prdata[31:`PRE_MSB+1] == '0)
        else $error("Reserved control bits did not read zero.");

    write_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && pwrite) |=> prdata == 32'h0000_0000)
        else $error("Read data not zero after a write setup.");

    flag_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!reach_zero && !zero_reached_flag_reg) |=> !zero_reached_flag_reg)
        else $error("Flag set without the counter reaching zero.");

    irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !zero_irq_enable_reg |-> !zero_irq)
        else $error("Request seen while interrupt enable is clear.");

    reload_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        reload_load);
    roll_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        tick && count_reg == `CNT_ZERO && !reload_select_reg);
    overwrite_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        overwrite_load && run);
    irq_rise_c: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(zero_irq));
    doze_hold_c: cover property (@(posedge pclk) disable iff (!presetn)
        run_enable_reg && doze_mode && doze_stop_reg);

endmodule

// ### verification/irq_controller_model.sv
`timescale 1ns/100ps

module irq_controller_model (
    // Clock and reset.
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Request from the timer.
    input  wire logic  zero_irq,
    // Number of requests taken.
    output int unsigned irq_count
);
    logic irq_seen_reg;

    // The request is a level, so only its rising edge opens a new service.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_seen_reg <= 1'b0;
            irq_count    <= 0;
        end else begin
            irq_seen_reg <= zero_irq;
            if (zero_irq === 1'b1 && irq_seen_reg === 1'b0) begin
                irq_count <= irq_count + 1;
            end
        end
    end
endmodule

// ### verification/tb_periodic_down_timer.sv
`timescale 1ns/100ps
`include "timer_defines.svh"

module tb_periodic_down_timer
    import timer_pkg::*;
;
    localparam logic [11:0] CS  = {`CS_INDEX, 2'b00};
    localparam logic [11:0] MD  = {`MOD_INDEX, 2'b00};
    localparam logic [11:0] CN  = {`CNT_INDEX, 2'b00};
    localparam word16_type  EN  = 16'h0001 << `EN_BIT;
    localparam word16_type  RL  = 16'h0001 << `RLD_BIT;
    localparam word16_type  FL  = 16'h0001 << `FLAG_BIT;
    localparam word16_type  IE  = 16'h0001 << `IE_BIT;
    localparam word16_type  OV  = 16'h0001 << `OVW_BIT;
    localparam word16_type  DB  = 16'h0001 << `DBG_BIT;
    localparam word16_type  DZ  = 16'h0001 << `DOZE_BIT;

    logic               pclk, presetn, psel, penable, pwrite, doze_mode, debug_mode;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready, pslverr, zero_irq;
    int                 fail_count, tests_run, n;
    int unsigned        irq_count;
    logic [33:0]        exp_q[$];
    word16_type         m;

    periodic_down_timer i_dut (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .doze_mode  (doze_mode),
        .debug_mode (debug_mode),
        .zero_irq   (zero_irq)
    );

    irq_controller_model i_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .zero_irq  (zero_irq),
        .irq_count (irq_count)
    );

    always #4 pclk = ~pclk;

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input word16_type d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Callers never set the reserved control bit.
    task automatic wr(input logic [11:0] a, input word16_type d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input word16_type d, input logic irq, input logic err);
        exp_q.push_back({err, irq, 16'h0000, d});
        apb(1'b0, a, 16'h0000);
    endtask

    // Lets the timer run for exactly n clock edges, then freezes it again.
    task automatic run_for(input int cycles);
        @(posedge pclk);
        debug_mode <= 1'b0;
        repeat (cycles) @(posedge pclk);
        debug_mode <= 1'b1;
    endtask

    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() > 0) cmp({pslverr, zero_irq, prdata}, exp_q.pop_front());
        end
    end

    // At most about 480 cycles are needed; twenty thousand leaves a wide margin.
    initial begin
        #(8 * 20000);
        fail_count++;
        stop_test();
    end

    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        doze_mode  = 1'b0;
        debug_mode = 1'b1;
        fail_count = 0;
        tests_run  = 0;
        void'($urandom(17));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(CS, 16'h0000, 1'b0, 1'b0);
        rd(MD, 16'hffff, 1'b0, 1'b0);
        rd(CN, 16'hffff, 1'b0, 1'b0);
        rd(12'h00c, 16'h0000, 1'b0, 1'b1);
        rd(12'h002, 16'h0000, 1'b0, 1'b1);
        wr(12'h00c, 16'h00ff);
        rd(CS, 16'h0000, 1'b0, 1'b0);
        $display("test reset finished");
        wr(CS, EN | DB | OV | IE | RL);
        wr(MD, 16'h0004);
        rd(CN, 16'h0004, 1'b0, 1'b0);
        run_for(5);
        rd(CN, 16'h0004, 1'b1, 1'b0);
        rd(CS, EN | DB | OV | IE | RL | FL, 1'b1, 1'b0);
        wr(CS, EN | DB | OV | RL);
        rd(CS, EN | DB | OV | RL | FL, 1'b0, 1'b0);
        wr(CS, EN | DB | OV | RL | IE | FL);
        rd(CS, EN | DB | OV | RL | IE, 1'b0, 1'b0);
        cmp(34'(irq_count), 34'd1);
        $display("test reload finished");
        wr(CS, EN | DB | OV | IE);
        wr(MD, 16'h0002);
        run_for(4);
        rd(CN, 16'hfffe, 1'b1, 1'b0);
        rd(MD, 16'h0002, 1'b1, 1'b0);
        cmp(34'(irq_count), 34'd2);
        wr(CS, EN | DB | IE);
        wr(MD, 16'h0007);
        rd(CN, 16'hfffe, 1'b0, 1'b0);
        rd(MD, 16'h0007, 1'b0, 1'b0);
        wr(CS, EN | DB | OV | RL);
        wr(MD, 16'h0003);
        wr(CS, EN | DB | RL);
        wr(MD, 16'h0009);
        rd(CN, 16'h0003, 1'b0, 1'b0);
        run_for(4);
        rd(CN, 16'h0009, 1'b0, 1'b0);
        $display("test modes finished");
        for (int p = 0; p < 5; p++) begin
            m = 16'h0100 + 16'($urandom_range(0, 4095));
            n = $urandom_range(8, 40);
            wr(CS, EN | DB | OV | word16_type'(p << `PRE_LSB));
            wr(MD, m);
            run_for(n);
            rd(CN, m - word16_type'(n >> p), 1'b0, 1'b0);
        end
        wr(CS, EN | DB | OV | 16'h0200);
        wr(MD, 16'd30);
        run_for(3);
        wr(CS, EN | DB | OV | 16'h0300);
        run_for(7);
        rd(CN, 16'd30, 1'b0, 1'b0);
        run_for(1);
        rd(CN, 16'd29, 1'b0, 1'b0);
        $display("test prescaler finished");
        wr(CS, EN | DB | DZ | OV);
        wr(MD, 16'd200);
        doze_mode <= 1'b1;
        run_for(6);
        rd(CN, 16'd200, 1'b0, 1'b0);
        wr(CS, EN | DB | OV);
        run_for(6);
        rd(CN, 16'd194, 1'b0, 1'b0);
        doze_mode <= 1'b0;
        wr(CS, DB | OV);
        run_for(6);
        rd(CN, 16'd194, 1'b0, 1'b0);
        rd(CS, DB | OV, 1'b0, 1'b0);
        wr(CS, EN | DB | OV);
        wr(MD, 16'd50);
        wr(CS, EN | OV);
        wr(CS, EN | DB | OV);
        wr(CN, 16'h1234);
        rd(CN, 16'd47, 1'b0, 1'b0);
        rd(CS, EN | DB | OV, 1'b0, 1'b0);
        $display("test freeze finished");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CS, 16'h0000, 1'b0, 1'b0);
        rd(MD, 16'hffff, 1'b0, 1'b0);
        $display("test second reset finished");
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule
